// ### rtl/ext_data_memory_bus_port.sv
// Function
// - bank select low X, high Y
// - address holds last value when idle
// - reset drives address to zero
// - zero address kept until first access
// - sixteen-bit two-way data bus
// - bus-owned strobe low while we occupy bus
// - grant low when outside master allowed
// - grant low floats select, address, data, strobes
// - wait input stretches reads
`timescale 1ns/1ps
`include "ext_mem_params.svh"
module ext_data_memory_bus_port
	import ext_mem_pkg::*;
(
	input  wire logic               clk_i,                  // 40 MHz system clock
	input  wire logic               rst_b_i,                // sync reset, active low
	input  ext_mem_pkg::mem_req_t   req_i,                  // core access request
	output ext_mem_pkg::mem_rsp_t   rsp_o,                  // access completion
	output logic                    busy_o,                 // request accepted, not done
	output logic                    bank_sel_o,             // 0 = X, 1 = Y memory
	output logic [13:0]             ext_addr_bus_o,         // address bus
	output logic                    ext_addr_bus_oe_o,      // address/select/strobe enable
	input  wire logic [15:0]        ext_data_bus_i,         // data bus input
	output logic [15:0]             ext_data_bus_o,         // data bus output
	output logic                    ext_data_bus_oe_o,      // data bus enable
	output logic                    mem_read_strobe_b_o,    // read strobe, active low
	output logic                    mem_write_strobe_b_o,   // write strobe, active low
	input  wire logic               wait_i,                 // wait request, active high
	input  wire logic               bus_hold_request_b_i,   // hold request, active low
	output logic                    bus_hold_grant_b_o,     // hold grant, active low
	output logic                    bus_owned_strobe_b_o    // bus occupied, active low
);
	import ext_mem_pkg::*;

	typedef struct packed {
		port_state_t st;
		mem_req_t    req;
		mem_pins_t   pins;
		mem_rsp_t    rsp;
		logic        busy;
		logic        grant_b;
		logic        owned_b;
	} port_t;
	port_t s_q, s_d;
	logic  tmr_start;
	logic  tmr_expire;

	strobe_timer u_timer (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.start_i  (tmr_start),
		.expire_o (tmr_expire)
	);

	always_comb begin
		s_d = s_q;
		tmr_start = 1'b0;
		s_d.rsp.done = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				// a hold request is only granted between accesses, never mid-strobe
				if (!bus_hold_request_b_i) begin
					s_d.st = ST_HELD;
					s_d.grant_b = 1'b0;
					s_d.pins.pins_oe = 1'b0;
					s_d.pins.data_oe = 1'b0;
				end else if (req_i.valid) begin
					s_d.st = ST_STROBE;
					s_d.req = req_i;
					s_d.busy = 1'b1;
					s_d.owned_b = 1'b0;
					s_d.pins.bank_sel = req_i.bank_y ? `BANK_Y : `BANK_X;
					s_d.pins.addr = req_i.addr;
					s_d.pins.read_b = req_i.write;
					s_d.pins.write_b = !req_i.write;
					s_d.pins.data_out = req_i.wdata;
					s_d.pins.data_oe = req_i.write;
					tmr_start = 1'b1;
				end
			end
			ST_STROBE: begin
				if (tmr_expire) begin
					s_d.st = s_q.req.write ? ST_DONE : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!wait_i) begin
					s_d.rsp.rdata = ext_data_bus_i;
					s_d.st = ST_DONE;
				end
			end
			ST_DONE: begin
				// address and select stay put after the access
				s_d.pins.read_b = 1'b1;
				s_d.pins.write_b = 1'b1;
				s_d.pins.data_oe = 1'b0;
				s_d.owned_b = 1'b1;
				s_d.busy = 1'b0;
				s_d.rsp.done = 1'b1;
				s_d.st = ST_IDLE;
			end
			ST_HELD: begin
				if (bus_hold_request_b_i) begin
					s_d.st = ST_IDLE;
					s_d.grant_b = 1'b1;
					s_d.pins.pins_oe = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.pins.addr <= `ADDR_RST;
			s_q.pins.read_b <= 1'b1;
			s_q.pins.write_b <= 1'b1;
			s_q.pins.pins_oe <= 1'b1;
			s_q.grant_b <= 1'b1;
			s_q.owned_b <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp_o                = s_q.rsp;
	assign busy_o               = s_q.busy;
	assign bank_sel_o           = s_q.pins.bank_sel;
	assign ext_addr_bus_o       = s_q.pins.addr;
	assign ext_addr_bus_oe_o    = s_q.pins.pins_oe;
	assign ext_data_bus_o       = s_q.pins.data_out;
	assign ext_data_bus_oe_o    = s_q.pins.data_oe;
	assign mem_read_strobe_b_o  = s_q.pins.read_b;
	assign mem_write_strobe_b_o = s_q.pins.write_b;
	assign bus_hold_grant_b_o   = s_q.grant_b;
	assign bus_owned_strobe_b_o = s_q.owned_b;

	a_bank_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.st == ST_IDLE && bus_hold_request_b_i && req_i.valid) |=> bank_sel_o == $past(req_i.bank_y))
		else $error("bank select does not follow request");
	a_addr_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.st != ST_IDLE) |=> $stable(ext_addr_bus_o))
		else $error("address changed outside access start");
	a_addr_reset: assert property (@(posedge clk_i)
		!rst_b_i |=> ext_addr_bus_o == 14'h0000)
		else $error("address not zero after reset");
	// address may only move on the edge that takes a request, so the reset zero survives until then
	a_addr_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(s_q.st == ST_IDLE && bus_hold_request_b_i && req_i.valid) |=> $stable(ext_addr_bus_o))
		else $error("address moved without an access");
	a_data_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ext_data_bus_oe_o |-> !mem_write_strobe_b_o && mem_read_strobe_b_o)
		else $error("data driven outside a write");
	a_owned_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!mem_read_strobe_b_o || !mem_write_strobe_b_o) |-> !bus_owned_strobe_b_o)
		else $error("strobe active without bus owned");
	a_grant_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.st == ST_IDLE && !bus_hold_request_b_i) |=> !bus_hold_grant_b_o)
		else $error("hold request not granted");
	a_float_bus: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!bus_hold_grant_b_o |-> !ext_addr_bus_oe_o && !ext_data_bus_oe_o && bus_owned_strobe_b_o)
		else $error("pins driven while granted");
	a_wait_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.st == ST_WAIT && wait_i) |=> !mem_read_strobe_b_o && !rsp_o.done)
		else $error("read ended during wait");
	a_strobe_end: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rsp_o.done |-> mem_read_strobe_b_o && mem_write_strobe_b_o && bus_owned_strobe_b_o)
		else $error("strobe still active at completion");
endmodule

// ### rtl/ext_mem_params.svh
`ifndef EXT_MEM_PARAMS_SVH
`define EXT_MEM_PARAMS_SVH
`define ADDR_W        14
`define DATA_W        16
`define ADDR_RST      14'h0000
`define BANK_X        1'b0
`define BANK_Y        1'b1
// least strobe width in ns; cycles derived at 40 MHz (25 ns period), rounded up
`define STROBE_NS     25
`define CLK_PERIOD_NS 25
`define STROBE_CYC    ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### rtl/ext_mem_pkg.sv
package ext_mem_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_STROBE = 3'b001,
		ST_WAIT   = 3'b011,
		ST_DONE   = 3'b010,
		ST_HELD   = 3'b110
	} port_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        bank_y;
		logic [13:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        done;
		logic [15:0] rdata;
	} mem_rsp_t;

	typedef struct packed {
		logic        bank_sel;
		logic [13:0] addr;
		logic [15:0] data_out;
		logic        data_oe;
		logic        read_b;
		logic        write_b;
		logic        pins_oe;
	} mem_pins_t;
endpackage

// ### rtl/strobe_timer.sv
`timescale 1ns/1ps
`include "ext_mem_params.svh"
module strobe_timer
	import ext_mem_pkg::*;
(
	input  wire logic clk_i,    // system clock
	input  wire logic rst_b_i,  // sync reset, active low
	input  wire logic start_i,  // start a strobe interval
	output logic      expire_o  // one-cycle pulse when interval elapsed
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       run;
		logic       expire;
	} tmr_t;
	tmr_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.expire = 1'b0;
		if (start_i) begin
			s_d.run = 1'b1;
			s_d.cnt = 4'(`STROBE_CYC - 1);
		end else if (s_q.run) begin
			if (s_q.cnt == 4'h0) begin
				s_d.run = 1'b0;
				s_d.expire = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expire_o = s_q.expire;
endmodule

// ### test/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic        clk_i,         // system clock
	input  wire logic        bank_sel_i,    // 0 = X, 1 = Y
	input  wire logic [13:0] addr_i,        // address bus
	input  wire logic [15:0] data_i,        // resolved data bus
	input  wire logic        read_b_i,      // read strobe, active low
	input  wire logic        write_b_i,     // write strobe, active low
	input  wire logic        oe_i,          // port drives select/address/strobes
	input  wire logic [3:0]  wait_cycles_i, // wait length asked by the bench
	output logic [15:0]      data_o,        // memory drive onto data bus
	output logic             wait_o         // wait request, active high
);
	logic [15:0] mem_q [0:31];
	logic [15:0] last_q = 16'h0000;
	logic [3:0]  k_q    = 4'h0;
	wire         rd     = oe_i && !read_b_i;
	always @(posedge clk_i) begin
		k_q <= rd ? k_q + 4'h1 : 4'h0;
		if (oe_i && !write_b_i)
			mem_q[{bank_sel_i, addr_i[3:0]}] <= data_i;
		if (rd)
			last_q <= data_o;
	end
	// released bus shows the inverse of the last word so a stale value never passes
	assign data_o = rd ? mem_q[{bank_sel_i, addr_i[3:0]}] : ~last_q;
	// the port ignores wait during the strobe minimum, so wait starts on the third read cycle
	assign wait_o = rd && k_q >= 4'h2 && k_q < 4'h2 + wait_cycles_i;
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import ext_mem_pkg::*;
	logic        clk_i = 0, rst_b_i = 0, hold_b = 1, busy, bsel, aoe, doe, rd_b, wr_b, wt, gnt_b, own_b;
	mem_req_t    req = '0;
	mem_rsp_t    rsp;
	logic [13:0] addr;
	logic [15:0] dout, din, mem_d;
	logic [3:0]  wn = 4'h0;
	int          fail_count = 0, checks = 0;
	initial forever #12.5 clk_i = ~clk_i;
	assign din = doe ? dout : mem_d;
	ext_data_memory_bus_port dut (.clk_i, .rst_b_i, .req_i(req), .rsp_o(rsp), .busy_o(busy), .bank_sel_o(bsel),
		.ext_addr_bus_o(addr), .ext_addr_bus_oe_o(aoe), .ext_data_bus_i(din), .ext_data_bus_o(dout),
		.ext_data_bus_oe_o(doe), .mem_read_strobe_b_o(rd_b), .mem_write_strobe_b_o(wr_b), .wait_i(wt),
		.bus_hold_request_b_i(hold_b), .bus_hold_grant_b_o(gnt_b), .bus_owned_strobe_b_o(own_b));
	ext_mem_model mem (.clk_i, .bank_sel_i(bsel), .addr_i(addr), .data_i(din), .read_b_i(rd_b), .write_b_i(wr_b),
		.oe_i(aoe), .wait_cycles_i(wn), .data_o(mem_d), .wait_o(wt));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one access; latency counted in falling edges from the drive to the done pulse
	task automatic access(input logic w, y, input logic [13:0] a, input logic [15:0] v, input logic [3:0] n);
		int c;
		c = 0;
		wn = n;
		req = '{1'b1, w, y, a, v};
		while (own_b !== 1'b0 && c < 8) begin
			@(negedge clk_i);
			c++;
		end
		chk("owned", own_b, 1'b0);
		chk("busy", busy, 1'b1);
		chk("bank", bsel, y);
		chk("addr", addr, a);
		chk("rd strobe", rd_b, w);
		chk("wr strobe", wr_b, !w);
		chk("data oe", doe, w);
		if (w)
			chk("wdata", dout, v);
		while (rsp.done !== 1'b1 && c < 30) begin
			@(negedge clk_i);
			c++;
		end
		chk("latency", c, 4 + !w + n);
		chk("strobes off", {rd_b, wr_b, own_b, busy}, 4'he);
		if (!w)
			chk("rdata", rsp.rdata, v);
		req.valid = 1'b0;
		@(negedge clk_i);
		chk("done pulse", rsp.done, 1'b0);
		chk("owned idle", own_b, 1'b1);
		chk("addr hold", {addr, bsel}, {a, y});
	endtask
	task automatic hold_test(input logic [13:0] a);
		hold_b = 1'b0;
		repeat (3) @(negedge clk_i);
		chk("grant", gnt_b, 1'b0);
		chk("pins oe", {aoe, doe, own_b}, 3'h1);
		hold_b = 1'b1;
		repeat (3) @(negedge clk_i);
		chk("grant off", {gnt_b, aoe}, 2'h3);
		chk("addr after hold", addr, a);
	endtask
	// a hold request that arrives mid-read must wait until the read has finished
	task automatic hold_mid(input logic [13:0] a, input logic [15:0] v);
		int c;
		c = 0;
		wn = 4'h2;
		req = '{1'b1, 1'b0, 1'b1, a, 16'h0000};
		@(negedge clk_i);
		hold_b = 1'b0;
		while (rsp.done !== 1'b1 && c < 30) begin
			chk("grant mid access", gnt_b, 1'b1);
			@(negedge clk_i);
			c++;
		end
		chk("rdata mid hold", rsp.rdata, v);
		req.valid = 1'b0;
		@(negedge clk_i);
		chk("grant after access", {gnt_b, aoe, doe}, 3'h0);
		hold_b = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("release", {gnt_b, aoe, addr}, {2'h3, a});
	endtask
	task automatic reset_test;
		repeat (8) @(negedge clk_i);
		chk("reset pins", {addr, bsel, rd_b, wr_b, gnt_b, own_b, doe, rsp.done}, 21'h0003c);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk("addr before use", {addr, aoe}, 15'h0001);
	endtask
	initial begin
		#100us;
		fail_count++;
		close_out();
	end
	initial begin
		reset_test();
		access(1, 1, 14'h2a5, 16'hbeef, 0);
		access(0, 1, 14'h2a5, 16'hbeef, 0);
		access(1, 0, 14'h3f13, 16'h1234, 0);
		access(0, 0, 14'h3f13, 16'h1234, 3);
		hold_test(14'h3f13);
		hold_mid(14'h2a5, 16'hbeef);
		close_out();
	end
endmodule
